// file: design/psbsp_mem.v
// single-port word array with byte writes and registered read data
`timescale 1ns/1ps

module psbsp_mem #(
  parameter WORDS = 524288,
  parameter AW = 19,
  parameter NB = 4
) (
  input wire clk,
  input wire ce,
  input wire [AW-1:0] addr,
  input wire [NB-1:0] we,
  input wire [8*NB-1:0] wdata,
  output reg [8*NB-1:0] rdata
);

  reg [8*NB-1:0] mem [0:WORDS-1];

  // ---------------------------------------------------------------
  // read port: old contents on a write cycle
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (ce) begin
      rdata <= mem[addr];
    end
  end

  // ---------------------------------------------------------------
  // per-byte write lanes
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_lane
      always @(posedge clk) begin
        if (ce && we[b]) begin
          mem[addr][8*b +: 8] <= wdata[8*b +: 8];
        end
      end
    end
  endgenerate

endmodule // psbsp_mem

// file: design/psbsp_port.v
// pipelined burst sram access port, device side
`timescale 1ns/1ps
`include "psbsp_regs.vh"

// Function
// - 524,288 words of 32 bits, 2-bit burst
// - all synchronous inputs taken on rising edge
// - read data out one edge later
// - read on strobe, selected, no write
// - read start loads address and counter
// - drive data only while output enable low; the pins follow it two cycles late through the two-flop synchroniser
// - first cycle after selection stays tri-state
// - later cycles follow output enable
// - back-to-back single reads pipeline
// - deselect with strobe tri-states at once
// - processor strobe write loads address, counter
// - first processor cycle ignores write, advance
// - processor write lands at second edge
// - global write high: byte controls decide
// - only selected bytes written, rest kept
// - global write low writes all bytes
// - burst order from sampled order input
// - two-bit wrap counter steps on advance
// - write cycle forces data pins tri-state
// - advance low steps to next burst address
// - order high: start xor counter
// - order low: start plus counter, wrapped
// - controller strobe write completes in one cycle
module psbsp_port #(
  parameter WORDS = `PSBSP_WORDS,
  parameter AW = `PSBSP_ADDR_W
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [AW-1:0] addr,
  input wire [31:0] dq_i,
  output reg [31:0] dq_o,
  output reg dq_oe,
  input wire processor_addr_strobe_n,
  input wire controller_addr_strobe_n,
  input wire burst_advance_n,
  input wire global_write_n,
  input wire byte_write_enable_n,
  input wire [3:0] byte_select_n,
  input wire chip_sel_a_n,
  input wire chip_sel_b,
  input wire chip_sel_c_n,
  input wire out_enable_n,
  input wire burst_order,
  output reg [31:0] rd_data,
  output reg rd_valid,
  input wire rd_ready,
  output reg rd_buf_ready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg active_reg;
  reg rd_pend_reg;
  reg [1:0] cnt_reg;
  reg [1:0] start_lo_reg;
  reg [AW-3:0] hi_reg;
  reg oe_s1_reg;
  reg oe_s2_reg;
  reg ord_s1_reg;
  reg ord_s2_reg;
  reg [31:0] tail_reg;
  reg tail_v_reg;

  wire [31:0] mem_q;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire sel_ok;
  wire p_hit;
  wire c_hit;
  wire strobe;
  wire start;
  wire desel;
  wire continuing;
  wire [3:0] wr_mask;
  wire wr_any;
  wire do_write;
  wire do_read;

  assign sel_ok = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
  // processor strobe counts only with the first select low
  assign p_hit = ~processor_addr_strobe_n & ~chip_sel_a_n;
  assign c_hit = ~controller_addr_strobe_n & ~p_hit;
  assign strobe = p_hit | c_hit;
  assign start = strobe & sel_ok;
  assign desel = strobe & ~sel_ok;
  assign continuing = ~strobe & active_reg;

  // global write overrides the byte lanes
  assign wr_mask = ~global_write_n ? `PSBSP_MASK_ALL :
                   (~byte_write_enable_n ? ~byte_select_n :
                    `PSBSP_MASK_NONE);
  assign wr_any = |wr_mask;

  // first processor cycle never writes; controller start writes now
  assign do_write = (c_hit & start & wr_any) |
                    (continuing & wr_any);
  assign do_read = (start | continuing) & ~do_write;

  // ---------------------------------------------------------------
  // burst address
  // ---------------------------------------------------------------
  wire cnt_step;
  wire [1:0] cnt_next;
  wire [1:0] burst_lo;
  wire [AW-1:0] acc_addr;

  // a start cycle ignores advance
  assign cnt_step = continuing & ~burst_advance_n;
  assign cnt_next = start ? `PSBSP_CNT_RST :
                    (cnt_reg + (cnt_step ? `PSBSP_CNT_STEP : 2'h0));
  assign burst_lo = ord_s2_reg ? (start_lo_reg ^ cnt_next) :
                    (start_lo_reg + cnt_next);
  assign acc_addr = start ? addr : {hi_reg, burst_lo};

  // ---------------------------------------------------------------
  // word array
  // ---------------------------------------------------------------
  psbsp_mem #(
    .WORDS(WORDS),
    .AW(AW),
    .NB(`PSBSP_BYTES)
  ) u_mem (
    .clk(clk),
    .ce(ce),
    .addr(acc_addr),
    .we(do_write ? wr_mask : `PSBSP_MASK_NONE),
    .wdata(dq_i),
    .rdata(mem_q)
  );

  // ---------------------------------------------------------------
  // captured access state and pin synchronisers
  // ---------------------------------------------------------------
  // output enable and order arrive off-clock, so they pass two flops;
  // this costs two cycles of latency on the enable path
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      cnt_reg <= `PSBSP_CNT_RST;
      start_lo_reg <= 2'h0;
      hi_reg <= {(AW-2){1'b0}};
      oe_s1_reg <= 1'b1;
      oe_s2_reg <= 1'b1;
      ord_s1_reg <= 1'b1;
      ord_s2_reg <= 1'b1;
    end else if (ce) begin
      oe_s1_reg <= out_enable_n;
      oe_s2_reg <= oe_s1_reg;
      ord_s1_reg <= burst_order;
      ord_s2_reg <= ord_s1_reg;
      rd_pend_reg <= do_read;
      if (start) begin
        active_reg <= 1'b1;
        hi_reg <= addr[AW-1:2];
        start_lo_reg <= addr[1:0];
        cnt_reg <= `PSBSP_CNT_RST;
      end else if (desel) begin
        active_reg <= 1'b0;
      end else if (active_reg) begin
        cnt_reg <= cnt_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // data pins
  // ---------------------------------------------------------------
  // a fresh selection has no read word yet, so its first cycle is
  // tri-state; deselect and writes drop the drivers on that edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_o <= `PSBSP_DATA_RST;
      dq_oe <= 1'b0;
    end else if (ce) begin
      if (rd_pend_reg) begin
        dq_o <= mem_q;
      end
      dq_oe <= rd_pend_reg & ~oe_s2_reg &
               ~desel &
               ~do_write;
    end
  end

  // ---------------------------------------------------------------
  // two-entry read word buffer
  // ---------------------------------------------------------------
  // a word offered while the buffer is full is dropped; the host
  // watches rd_buf_ready and holds off reads
  reg [31:0] head_n;
  reg [31:0] tail_n;
  reg head_v_n;
  reg tail_v_n;
  wire pop;
  wire acc;

  assign pop = rd_valid & rd_ready;
  assign acc = rd_pend_reg & rd_buf_ready;

  always @* begin
    head_n = rd_data;
    tail_n = tail_reg;
    head_v_n = rd_valid;
    tail_v_n = tail_v_reg;
    if (pop) begin
      if (tail_v_reg) begin
        head_n = tail_reg;
        tail_v_n = 1'b0;
      end else begin
        head_v_n = 1'b0;
      end
    end
    if (acc) begin
      if (!head_v_n) begin
        head_n = mem_q;
        head_v_n = 1'b1;
      end else begin
        tail_n = mem_q;
        tail_v_n = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `PSBSP_DATA_RST;
      rd_valid <= 1'b0;
      tail_reg <= `PSBSP_DATA_RST;
      tail_v_reg <= 1'b0;
      rd_buf_ready <= 1'b1;
    end else if (ce) begin
      rd_data <= head_n;
      rd_valid <= head_v_n;
      tail_reg <= tail_n;
      tail_v_reg <= tail_v_n;
      rd_buf_ready <= ~(head_v_n & tail_v_n);
    end
  end

endmodule // psbsp_port

// file: design/psbsp_regs.vh
// constants for the pipelined burst sram port
`ifndef PSBSP_REGS_VH
`define PSBSP_REGS_VH

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define PSBSP_WORDS 524288
`define PSBSP_ADDR_W 19
`define PSBSP_DATA_W 32
`define PSBSP_BYTES 4

// ---------------------------------------------------------------
// burst counter
// ---------------------------------------------------------------
`define PSBSP_CNT_W 2
`define PSBSP_CNT_RST 2'h0
`define PSBSP_CNT_STEP 2'h1

// ---------------------------------------------------------------
// byte masks and reset values
// ---------------------------------------------------------------
`define PSBSP_MASK_ALL 4'hf
`define PSBSP_MASK_NONE 4'h0
`define PSBSP_DATA_RST 32'h0000_0000
`define PSBSP_HI_RST 17'h0_0000

`endif

// file: dv/pipelined_burst_sram_port_bench.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module pipelined_burst_sram_port_bench;
  logic clk, rst_n, ce, dq_oe, rd_valid, rd_ready, rd_buf_ready, hold;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  logic global_write_n, byte_write_enable_n, chip_sel_a_n, chip_sel_b;
  logic chip_sel_c_n, out_enable_n, burst_order;
  logic [3:0] addr, byte_select_n;
  logic [31:0] dq_i, dq_o, rd_data, m [16], q [$];
  int errors, cmp_count, i, seed = 32'h3c8b_7c99;
  psbsp_port #(.WORDS(16), .AW(4)) dut (.*);
  psbsp_sink sink (.hold(hold), .rd_ready(rd_ready));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task chk(input [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task cyc(input [7:0] c, input [3:0] b, a, input [31:0] d);
    if ($time > 0) @(negedge clk);
    {processor_addr_strobe_n, controller_addr_strobe_n, chip_sel_a_n,
      chip_sel_b, chip_sel_c_n, burst_advance_n, global_write_n,
      byte_write_enable_n} = c;
    byte_select_n = b;
    addr = a;
    dq_i = d;
  endtask
  task desel(input [1:0] k);
    cyc({2'b10, k == 0, k != 1, k == 2, 3'h7}, 4'hf, 4'h0, 32'h0);
  endtask
  task mw(input [3:0] a, input [31:0] d, input g, w, input [3:0] b);
    for (int j = 0; j < 4; j++)
      if (!g || (!w && !b[j])) m[a][8*j +: 8] = d[8*j +: 8];
  endtask
  // the buffer holds two words; a third arriving while full is dropped
  task push(input [31:0] w);
    if (q.size() < 2) q.push_back(w);
  endtask
  task burst(input [3:0] a, input int n, input o, rs);
    logic [31:0] e [4];
    logic [3:0] x;
    burst_order = o;
    out_enable_n = 0;
    repeat (3) @(negedge clk);
    desel(2'h2);
    for (int k = 0; k <= n; k++) begin
      x = {a[3:2], o ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
      if (rs) x = a + k[3:0];
      if (k < n) e[k] = m[x];
      if (k == n) desel({1'b0, o});
      else if (k == 0 || rs) cyc(8'h97, 4'hf, x, 32'h0);
      else cyc(8'hd3, 4'hf, ~x, 32'h0);
      if (k > 1) chk(dq_o, e[k-2]);
      if (k > 1) push(e[k-2]);
    end
    cyc(8'hd7, 4'hf, 4'h0, 32'h0);
    chk(dq_o, e[n-1]);
    push(e[n-1]);
  endtask
  task cw(input [3:0] a, input [31:0] d, input g, w, input [3:0] b);
    out_enable_n = 1;
    cyc({6'h24, g, w}, b, a, d);
    mw(a, d, g, w, b);
    desel(2'h1);
    chk(dq_oe, 32'h0);
    cyc(8'hd7, 4'hf, 4'h0, 32'h0);
  endtask
  task pw(input [3:0] a, input [31:0] d, input g, w, input [3:0] b);
    out_enable_n = 1;
    cyc(8'h50, 4'h0, a, ~d);
    cyc({6'h35, g, w}, b, ~a, d);
    desel(2'h0);
    push(m[a]);
    chk(dq_oe, 32'h0);
    mw(a, d, g, w, b);
    cyc(8'hd7, 4'hf, 4'h0, 32'h0);
  endtask
  always @(posedge clk)
    if (rst_n && rd_valid === 1'b1 && rd_ready) chk(rd_data, q.pop_front());
  task report_and_stop;
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, hold, ce, out_enable_n, burst_order} = 5'h03;
    cyc(8'hd7, 4'hf, 4'h0, 32'h0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    ce = 1;
    for (i = 0; i < 16; i++) cw(i[3:0], $random(seed), 1'b0, 1'b1, 4'hf);
    for (i = 0; i < 15; i++)
      cw(4'($random(seed)), $random(seed), 1'b1, 1'b0, i[3:0]);
    cw(4'h5, $random(seed), 1'b0, 1'b0, 4'ha);
    for (i = 0; i < 4; i++)
      pw(4'($random(seed)), $random(seed), i[0], 1'b0,
        4'($random(seed)) & 4'h7);
    for (i = 0; i < 16; i++) burst(i[3:0], 4, i[2], i[3]);
    hold = 1;
    for (i = 0; i < 3; i++) burst(i[3:0], 1, 1'b1, 1'b0);
    chk(rd_buf_ready, 32'h0);
    hold = 0;
    for (i = 0; i < 20 && q.size() > 0; i++) @(negedge clk);
    chk(q.size(), 32'h0);
    report_and_stop();
  end
endmodule // pipelined_burst_sram_port_bench
bind psbsp_port psbsp_chk chk_i (.*);

// file: dv/psbsp_port_assertions.sv
// concurrent checks on the sram port pins
`timescale 1ns/1ps
module psbsp_chk (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire processor_addr_strobe_n,
  input wire controller_addr_strobe_n,
  input wire global_write_n,
  input wire byte_write_enable_n,
  input wire chip_sel_a_n,
  input wire chip_sel_b,
  input wire chip_sel_c_n,
  input wire out_enable_n,
  input wire dq_oe,
  input wire rd_valid,
  input wire rd_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  wire ps = !processor_addr_strobe_n && !chip_sel_a_n;
  wire stb = ce && (ps || !controller_addr_strobe_n);
  wire wr = !global_write_n || !byte_write_enable_n;
  wire rd = stb && sel && (ps || !wr);
  wire dsl = stb && !sel;
  // oe must be low long enough to pass the synchroniser
  sequence oe_low;
    (ce && !out_enable_n) [*4];
  endsequence
  sequence proc_wr;
    stb && sel && ps ##1 ce && !stb && !global_write_n;
  endsequence
  chk_ctrl_write_off: assert property (
    stb && sel && !ps && wr |=> !dq_oe) else $error("write drove bus");
  chk_desel_off: assert property (
    dsl |=> !dq_oe) else $error("deselect drove bus");
  chk_oe_high_off: assert property (
    (ce && out_enable_n) [*4] |-> !dq_oe) else $error("bus on, oe high");
  chk_first_cycle_off: assert property (
    dsl ##1 rd |=> !dq_oe) else $error("first cycle drove bus");
  chk_stream_drive: assert property (
    oe_low ##0 rd ##1 (rd && !out_enable_n) |=> ce && !dsl && !wr |=> dq_oe)
    else $error("read stream not driven");
  chk_proc_write_off: assert property (
    proc_wr |=> !dq_oe) else $error("proc write drove bus");
  chk_stall_hold: assert property (
    rd_valid && !rd_ready |=> rd_valid) else $error("word lost in stall");
  chk_freeze_state: assert property (
    !ce |=> $stable(dq_oe) && $stable(rd_valid)) else $error("moved, no ce");
endmodule // psbsp_chk

// file: dv/psbsp_sink.sv
// read-word consumer behind the port's output buffer
`timescale 1ns/1ps
module psbsp_sink (
  input wire hold,
  output wire rd_ready
);
  // takes a word every cycle unless told to stall
  assign rd_ready = !hold;
endmodule // psbsp_sink
